// ===== logic/ldo_ctrl_reg.sv
/*
 One regulator control register: holds fixed-reset control bits and
 OTP-loaded enable and voltage bits. Assumes synchronous active-low reset
 and OTP defaults that are stable while reset is applied.
*/
`timescale 1ns/1ns
module ldo_ctrl_reg #(
   parameter logic [7:0] WRITE_MASK = 8'hff,
   parameter logic [7:0] OTP_MASK = 8'h1f
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Write port
   input wire logic wr_i,
   input wire logic [7:0] wdata_i,
   // Reset defaults
   input wire logic [7:0] otp_i,
   // Stored value
   output logic [7:0] value_o
);
   logic [7:0] value_q;
   logic [7:0] value_d;

   always_comb begin
      value_d = value_q;
      if (!rst_n_i) begin
         // Fixed bits clear, enable and code come from OTP
         value_d = (ldo_pkg::FIXED_RESET_VALUE & ~OTP_MASK) | (otp_i & OTP_MASK);  // R17
      end else if (wr_i) begin
         // Unimplemented bits are masked so they stay zero
         value_d = wdata_i & WRITE_MASK;  // R19
      end
   end

   always_ff @(posedge clk_i) begin
      value_q <= value_d;
   end

   assign value_o = value_q;
endmodule

// ===== logic/ldo_pkg.sv
/*
 Package for the regulator control register bank: offsets, field positions,
 reset values and widths. Assumes an 8-bit address/data register port.
*/
package ldo_pkg;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 8;
   localparam logic [7:0] AUX_LDO_B_CONTROL_ADDR = 8'h6d;
   localparam logic [7:0] SD_CARD_LDO_CONTROL_ADDR = 8'h6e;
   localparam logic [7:0] IO_3V3_LDO_CONTROL_ADDR = 8'h6f;
   localparam int unsigned OFF_SLEEP_SEL_BIT = 7;
   localparam int unsigned LOWPOWER_EN_BIT = 6;
   localparam int unsigned STANDBY_OFF_BIT = 5;
   localparam int unsigned ENABLE_BIT = 4;
   localparam int unsigned AUX_VCODE_W = 4;
   localparam int unsigned SHORT_VCODE_W = 2;
   localparam logic [7:0] FIXED_RESET_VALUE = 8'h00;
   localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;
   localparam logic [7:0] AUX_WRITE_MASK = 8'hff;
   localparam logic [7:0] SHORT_WRITE_MASK = 8'hf3;
   localparam logic [7:0] OTP_LOAD_MASK_AUX = 8'h1f;
   localparam logic [7:0] OTP_LOAD_MASK_SHORT = 8'h13;
endpackage

// ===== logic/ldo_regs.sv
/*
 Control register bank for three linear regulators: auxiliary LDO B,
 SD-card LDO and 3.3 V I/O LDO. Reached over the device's internal
 8-bit register port behind the serial host interface; the host may read
 and write at any time. OTP defaults arrive as static inputs.
// Operation
// (R1) aux_ldo_b bit 7: off or sleep
// (R2) aux_ldo_b bit 6: low-power enable
// (R3) aux_ldo_b bit 5: off in standby
// (R4) aux_ldo_b bit 4: regulator enable
// (R5) aux_ldo_b bits 3:0: voltage code
// (R6) sd_card_ldo at 0x6E, code 1:0
// (R7) sd_card_ldo bit 7: off or sleep
// (R8) sd_card_ldo bit 6: low-power enable
// (R9) sd_card_ldo bit 5: off in standby
// (R10) sd_card_ldo bit 4: regulator enable
// (R11) io_3v3_ldo at 0x6F, same layout
// (R12) io_3v3_ldo bit 7: off or sleep
// (R13) io_3v3_ldo bit 6: low-power enable
// (R14) io_3v3_ldo bit 5: off in standby
// (R15) io_3v3_ldo bit 4: regulator enable
// (R16) Host accesses allowed at any time
// (R17) Reset clears control, loads OTP fields
// (R18) Unmapped addresses read zero, ignore writes
// (R19) Bits 3:2 of short registers read zero
*/
`timescale 1ns/1ns
module ldo_regs (
   // Clock and reset
   input wire logic CORE_CLK_I,
   input wire logic RST_N_I,
   // Register port from the host interface
   input wire logic [7:0] REG_ADDR_I,
   input wire logic REG_WR_I,
   input wire logic REG_RD_I,
   input wire logic [7:0] REG_WDATA_I,
   output logic [7:0] REG_RDATA_O,
   // OTP defaults, static after start-up
   input wire logic [7:0] OTP_AUX_LDO_B_I,
   input wire logic [7:0] OTP_SD_CARD_LDO_I,
   input wire logic [7:0] OTP_IO_3V3_LDO_I,
   // Regulator controls, auxiliary LDO B
   output logic AUX_LDO_B_OFF_SLEEP_SEL_O,
   output logic AUX_LDO_B_LOWPOWER_EN_O,
   output logic AUX_LDO_B_STANDBY_OFF_O,
   output logic AUX_LDO_B_ENABLE_O,
   output logic [3:0] AUX_LDO_B_VOLTAGE_CODE_O,
   // Regulator controls, SD-card LDO
   output logic SD_CARD_LDO_OFF_SLEEP_SEL_O,
   output logic SD_CARD_LDO_LOWPOWER_EN_O,
   output logic SD_CARD_LDO_STANDBY_OFF_O,
   output logic SD_CARD_LDO_ENABLE_O,
   output logic [1:0] SD_CARD_LDO_O,
   // Regulator controls, 3.3 V I/O LDO
   output logic IO_3V3_LDO_OFF_SLEEP_SEL_O,
   output logic IO_3V3_LDO_LOWPOWER_EN_O,
   output logic IO_3V3_LDO_STANDBY_OFF_O,
   output logic IO_3V3_LDO_ENABLE_O,
   output logic [1:0] IO_3V3_LDO_O
);
   logic [7:0] aux_q;
   logic [7:0] sd_q;
   logic [7:0] io_q;
   logic wr_aux;
   logic wr_sd;
   logic wr_io;
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;

   function automatic logic hit(input logic [7:0] addr, input logic [7:0] base);
      hit = (addr == base);
   endfunction

   // No busy or state gating: writes land whenever presented
   assign wr_aux = REG_WR_I & hit(REG_ADDR_I, ldo_pkg::AUX_LDO_B_CONTROL_ADDR);  // R16
   assign wr_sd = REG_WR_I & hit(REG_ADDR_I, ldo_pkg::SD_CARD_LDO_CONTROL_ADDR);  // R6
   assign wr_io = REG_WR_I & hit(REG_ADDR_I, ldo_pkg::IO_3V3_LDO_CONTROL_ADDR);  // R11

   ldo_ctrl_reg #(
      .WRITE_MASK(ldo_pkg::AUX_WRITE_MASK),
      .OTP_MASK(ldo_pkg::OTP_LOAD_MASK_AUX)
   ) u_aux (
      .clk_i(CORE_CLK_I),
      .rst_n_i(RST_N_I),
      .wr_i(wr_aux),
      .wdata_i(REG_WDATA_I),
      .otp_i(OTP_AUX_LDO_B_I),
      .value_o(aux_q)
   );

   ldo_ctrl_reg #(
      .WRITE_MASK(ldo_pkg::SHORT_WRITE_MASK),
      .OTP_MASK(ldo_pkg::OTP_LOAD_MASK_SHORT)
   ) u_sd (
      .clk_i(CORE_CLK_I),
      .rst_n_i(RST_N_I),
      .wr_i(wr_sd),
      .wdata_i(REG_WDATA_I),
      .otp_i(OTP_SD_CARD_LDO_I),
      .value_o(sd_q)
   );

   ldo_ctrl_reg #(
      .WRITE_MASK(ldo_pkg::SHORT_WRITE_MASK),
      .OTP_MASK(ldo_pkg::OTP_LOAD_MASK_SHORT)
   ) u_io (
      .clk_i(CORE_CLK_I),
      .rst_n_i(RST_N_I),
      .wr_i(wr_io),
      .wdata_i(REG_WDATA_I),
      .otp_i(OTP_IO_3V3_LDO_I),
      .value_o(io_q)
   );

   // Read data registered; held between reads
   always_comb begin
      rdata_d = rdata_q;
      if (!RST_N_I) begin
         rdata_d = ldo_pkg::UNMAPPED_READ_VALUE;
      end else if (REG_RD_I) begin
         case (REG_ADDR_I)
            ldo_pkg::AUX_LDO_B_CONTROL_ADDR: begin
               rdata_d = aux_q;
            end
            ldo_pkg::SD_CARD_LDO_CONTROL_ADDR: begin
               rdata_d = sd_q;  // R19
            end
            ldo_pkg::IO_3V3_LDO_CONTROL_ADDR: begin
               rdata_d = io_q;  // R19
            end
            default: begin
               rdata_d = ldo_pkg::UNMAPPED_READ_VALUE;  // R18
            end
         endcase
      end
   end

   always_ff @(posedge CORE_CLK_I) begin
      rdata_q <= rdata_d;
   end

   assign REG_RDATA_O = rdata_q;

   // Outputs come straight from the register flops
   assign AUX_LDO_B_OFF_SLEEP_SEL_O = aux_q[ldo_pkg::OFF_SLEEP_SEL_BIT];  // R1
   assign AUX_LDO_B_LOWPOWER_EN_O = aux_q[ldo_pkg::LOWPOWER_EN_BIT];  // R2
   assign AUX_LDO_B_STANDBY_OFF_O = aux_q[ldo_pkg::STANDBY_OFF_BIT];  // R3
   assign AUX_LDO_B_ENABLE_O = aux_q[ldo_pkg::ENABLE_BIT];  // R4
   assign AUX_LDO_B_VOLTAGE_CODE_O = aux_q[ldo_pkg::AUX_VCODE_W-1:0];  // R5
   assign SD_CARD_LDO_OFF_SLEEP_SEL_O = sd_q[ldo_pkg::OFF_SLEEP_SEL_BIT];  // R7
   assign SD_CARD_LDO_LOWPOWER_EN_O = sd_q[ldo_pkg::LOWPOWER_EN_BIT];  // R8
   assign SD_CARD_LDO_STANDBY_OFF_O = sd_q[ldo_pkg::STANDBY_OFF_BIT];  // R9
   assign SD_CARD_LDO_ENABLE_O = sd_q[ldo_pkg::ENABLE_BIT];  // R10
   assign SD_CARD_LDO_O = sd_q[ldo_pkg::SHORT_VCODE_W-1:0];  // R6
   assign IO_3V3_LDO_OFF_SLEEP_SEL_O = io_q[ldo_pkg::OFF_SLEEP_SEL_BIT];  // R12
   assign IO_3V3_LDO_LOWPOWER_EN_O = io_q[ldo_pkg::LOWPOWER_EN_BIT];  // R13
   assign IO_3V3_LDO_STANDBY_OFF_O = io_q[ldo_pkg::STANDBY_OFF_BIT];  // R14
   assign IO_3V3_LDO_ENABLE_O = io_q[ldo_pkg::ENABLE_BIT];  // R15
   assign IO_3V3_LDO_O = io_q[ldo_pkg::SHORT_VCODE_W-1:0];  // R11
endmodule

// ===== verification/ldo_host.sv
/* Host model: register reads and writes. Assumes strobes taken on the rising edge. */
`timescale 1ns/1ns
module ldo_host (
   input wire logic clk_i,
   output logic [7:0] addr_o,
   output logic [7:0] wdata_o,
   output logic wr_o,
   output logic rd_o
);
   initial {addr_o, wdata_o, wr_o, rd_o} = 18'h0;
   task automatic acc(input logic w, r, input logic [7:0] a, d);
      @(negedge clk_i);
      {addr_o, wdata_o, wr_o, rd_o} = {a, d, w, r};
      @(negedge clk_i);
      // Inverted leftovers, so a stale address never passes for a live one
      {addr_o, wdata_o, wr_o, rd_o} = {~a, ~d, 2'b00};
   endtask
endmodule

// ===== verification/ldo_regs_assertions.sv
/* Register port checker for ldo_regs. Assumes it is bound onto the bank. */
`timescale 1ns/1ns
module ldo_regs_chk (
   // Clock and reset
   input wire logic CORE_CLK_I,
   input wire logic RST_N_I,
   // Register port
   input wire logic REG_WR_I,
   input wire logic REG_RD_I,
   input wire logic [7:0] REG_ADDR_I,
   input wire logic [7:0] REG_WDATA_I,
   input wire logic [7:0] REG_RDATA_O,
   // Defaults and regulator controls
   input wire logic [7:0] OTP_AUX_LDO_B_I,
   input wire logic AUX_LDO_B_ENABLE_O,
   input wire logic [1:0] SD_CARD_LDO_O
);
   default clocking @(posedge CORE_CLK_I); endclocking
   default disable iff (!RST_N_I);
   sequence s_wrd(a);
      REG_WR_I && REG_ADDR_I == a ##1 !REG_WR_I ##1 REG_RD_I && !REG_WR_I && REG_ADDR_I == a;
   endsequence
   sequence s_boot;
      !RST_N_I ##1 RST_N_I && !REG_WR_I ##1 RST_N_I && REG_RD_I && REG_ADDR_I == 8'h6d;
   endsequence
   property p_back(a, m);
      s_wrd(a) |=> REG_RDATA_O == ($past(REG_WDATA_I, 3) & m);
   endproperty
   // Reset must not cancel this one, it is about reset itself
   property p_boot;
      disable iff (1'b0) s_boot |=> REG_RDATA_O == ($past(OTP_AUX_LDO_B_I, 3) & 8'h1f);
   endproperty
   a_aux_back: assert property (p_back(8'h6d, 8'hff)) else $error("aux readback");
   a_sd_back: assert property (p_back(8'h6e, 8'hf3)) else $error("sd readback");
   a_io_back: assert property (p_back(8'h6f, 8'hf3)) else $error("io readback");
   a_gap_bits_zero: assert property (REG_RD_I && REG_ADDR_I inside {8'h6e, 8'h6f} |=> !REG_RDATA_O[3:2])
      else $error("bits 3:2 set");
   a_hole_reads_zero: assert property (REG_RD_I && !(REG_ADDR_I inside {[8'h6d:8'h6f]}) |=> REG_RDATA_O == 8'h00)
      else $error("unmapped read");
   a_rdata_holds: assert property (!REG_RD_I |=> $stable(REG_RDATA_O)) else $error("read data moved");
   a_reset_clears: assert property (disable iff (1'b0) !RST_N_I |=> REG_RDATA_O == 8'h00) else $error("rdata");
   a_reset_otp: assert property (p_boot) else $error("otp load");
   a_aux_enable_out: assert property (REG_WR_I && REG_ADDR_I == 8'h6d |=> AUX_LDO_B_ENABLE_O == $past(REG_WDATA_I[4]))
      else $error("aux enable output");
   a_sd_code_out: assert property (REG_WR_I && REG_ADDR_I == 8'h6e |=> SD_CARD_LDO_O == $past(REG_WDATA_I[1:0]))
      else $error("sd code output");
endmodule
bind ldo_regs ldo_regs_chk u_chk (.CORE_CLK_I, .RST_N_I, .REG_WR_I, .REG_RD_I, .REG_ADDR_I, .REG_WDATA_I,
   .REG_RDATA_O, .OTP_AUX_LDO_B_I, .AUX_LDO_B_ENABLE_O, .SD_CARD_LDO_O);

// ===== verification/tb.sv
/* Bench for ldo_regs: write table with readback, then awkward cases. Uses ldo_host. */
`timescale 1ns/1ns
module tb;
   logic clk, rst_n, wr, rd;
   logic [7:0] addr, wdata, rdata, oa, os, oi;
   wire [7:0] aux, sd, io;
   int err_total = 0;
   int n_compared = 0;
   logic [23:0] rows [8] = '{24'h6dffff, 24'h6efff3, 24'h6ffff3, 24'h6d5a5a, 24'h6e8d81, 24'h6f6e62,
      24'h70ff00, 24'h6ca500};
   ldo_host u_host (.clk_i(clk), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
   ldo_regs u_dut (.CORE_CLK_I(clk), .RST_N_I(rst_n), .REG_ADDR_I(addr), .REG_WR_I(wr), .REG_RD_I(rd),
      .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .OTP_AUX_LDO_B_I(oa), .OTP_SD_CARD_LDO_I(os),
      .OTP_IO_3V3_LDO_I(oi), .AUX_LDO_B_OFF_SLEEP_SEL_O(aux[7]), .AUX_LDO_B_LOWPOWER_EN_O(aux[6]),
      .AUX_LDO_B_STANDBY_OFF_O(aux[5]), .AUX_LDO_B_ENABLE_O(aux[4]), .AUX_LDO_B_VOLTAGE_CODE_O(aux[3:0]),
      .SD_CARD_LDO_OFF_SLEEP_SEL_O(sd[7]), .SD_CARD_LDO_LOWPOWER_EN_O(sd[6]), .SD_CARD_LDO_STANDBY_OFF_O(sd[5]),
      .SD_CARD_LDO_ENABLE_O(sd[4]), .SD_CARD_LDO_O(sd[1:0]), .IO_3V3_LDO_OFF_SLEEP_SEL_O(io[7]),
      .IO_3V3_LDO_LOWPOWER_EN_O(io[6]), .IO_3V3_LDO_STANDBY_OFF_O(io[5]), .IO_3V3_LDO_ENABLE_O(io[4]),
      .IO_3V3_LDO_O(io[1:0]));
   assign sd[3:2] = 2'b00;
   assign io[3:2] = 2'b00;
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   function automatic logic [7:0] fld(input logic [7:0] a);
      return a == 8'h6d ? aux : a == 8'h6e ? sd : a == 8'h6f ? io : 8'h00;
   endfunction
   task automatic chk(input logic [7:0] got, exp);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic rdc(input logic [7:0] a, exp);
      u_host.acc(1'b0, 1'b1, a, 8'h00);
      chk(rdata, exp);
   endtask
   task automatic rst(input int n);
      rst_n = 1'b0;
      repeat (n) @(negedge clk);
      rst_n = 1'b1;
      chk(rdata, 8'h00);
      chk(aux, oa & 8'h1f);
      chk(sd, os & 8'h13);
      chk(io, oi & 8'h13);
      rdc(8'h6d, oa & 8'h1f);
      rdc(8'h6e, os & 8'h13);
      rdc(8'h6f, oi & 8'h13);
   endtask
   task automatic stop_test;
      $display("compares %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      oa = 8'hea;
      os = 8'hff;
      oi = 8'h5d;
      rst(10);
      foreach (rows[k]) begin
         u_host.acc(1'b1, 1'b0, rows[k][23:16], rows[k][15:8]);
         chk(fld(rows[k][23:16]), rows[k][7:0]);
         rdc(rows[k][23:16], rows[k][7:0]);
      end
      // Writes to the unmapped rows must have left every register alone
      chk(aux, 8'h5a);
      chk(sd, 8'h81);
      chk(io, 8'h62);
      // Same-cycle read and write: the read sees the contents from before
      u_host.acc(1'b1, 1'b1, 8'h6e, 8'h30);
      chk(rdata, 8'h81);
      rdc(8'h6e, 8'h30);
      oa = 8'h15;
      os = 8'h6c;
      oi = 8'h02;
      rst(2);
      stop_test();
   end
   initial begin
      #20000;
      err_total++;
      stop_test();
   end
endmodule
